// ===== design/ebc_pkg.sv
/*
 external bus cycle controller: register map, field layout, reset values, phase type.
 assumes an AXI4-Lite master with 32-bit data and byte offsets in the low address bits.
*/
// Summary of operation
// RQ1: five phases in fixed order per cycle
// RQ2: phase lengths from per-select timing register
// RQ3: setup 1-2 periods, +0-3 on window change
// RQ4: delay/hold 0-3, data setup 0-1 periods
// RQ5: access 1-32 periods, ready may extend
// RQ6: read data captured as strobe ends
// RQ7: address change cannot corrupt captured read
// RQ8: memory may drop data after strobe rises
// RQ9: mux shares lines, demux splits them
// RQ10: reference clock runs at system clock
// RQ11: inactive ready inserts wait, active ends
// RQ12: ready polarity selectable, async adds stage
// RQ13: memory removes ready before next sample
// RQ14: zero-length phase is skipped same edge
package ebc_pkg;
	localparam int REG_AW     = 8;
	localparam int ADDR_LINES = 24;
	localparam int DATA_LINES = 16;

	localparam logic [REG_AW-1:0] OFF_CTRL  = 8'h00;
	localparam logic [REG_AW-1:0] OFF_ADDR  = 8'h04;
	localparam logic [REG_AW-1:0] OFF_CMD   = 8'h08;
	localparam logic [REG_AW-1:0] OFF_WDATA = 8'h0C;
	localparam logic [REG_AW-1:0] OFF_STAT  = 8'h10;
	localparam logic [REG_AW-1:0] OFF_RDATA = 8'h14;
	localparam logic [2:0]        TCFG_PAGE = 3'h1;

	localparam int        CTRL_RPOL   = 0;
	localparam int        CTRL_RASYNC = 1;
	localparam int        CTRL_REFEN  = 2;
	localparam int        CTRL_W      = 3;
	localparam logic [2:0] CTRL_RST   = 3'h1;

	localparam int CMD_WR  = 0;
	localparam int CMD_BHE = 1;
	localparam int CMD_CS  = 8;

	localparam int         CFG_AB  = 0;
	localparam int         CFG_C   = 1;
	localparam int         CFG_D   = 3;
	localparam int         CFG_E   = 4;
	localparam int         CFG_F   = 9;
	localparam int         CFG_WIN = 11;
	localparam int         CFG_RDY = 13;
	localparam int         CFG_MUX = 14;
	localparam int         CFG_W   = 15;
	localparam logic [14:0] CFG_RST = 15'h0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {PH_IDLE, PH_AB, PH_C, PH_D, PH_E, PH_F} ph_type;
endpackage

// ===== design/ext_bus_ctrl.sv
/*
 external bus cycle controller: runs phased read/write cycles on a parallel bus,
 programmed over AXI4-Lite. assumes the memory is timed to bus_ref_clock and
 that ready_in may be asynchronous to core_clk.
*/
`timescale 1ns/10ps
module ext_bus_ctrl #(
	parameter int NUM_CS = 2
) (
	input  wire logic                             core_clk,           // system clock
	input  wire logic                             nrst,               // sync reset, active low
	input  wire logic                             s_axi_awvalid,      // write address valid
	output logic                                  s_axi_awready,      // write address ready
	input  wire logic [ebc_pkg::REG_AW-1:0]       s_axi_awaddr,       // write byte address
	input  wire logic                             s_axi_wvalid,       // write data valid
	output logic                                  s_axi_wready,       // write data ready
	input  wire logic [31:0]                      s_axi_wdata,        // write data
	input  wire logic [3:0]                       s_axi_wstrb,        // byte strobes
	output logic                                  s_axi_bvalid,       // write response valid
	input  wire logic                             s_axi_bready,       // write response ready
	output logic [1:0]                            s_axi_bresp,        // write response
	input  wire logic                             s_axi_arvalid,      // read address valid
	output logic                                  s_axi_arready,      // read address ready
	input  wire logic [ebc_pkg::REG_AW-1:0]       s_axi_araddr,       // read byte address
	output logic                                  s_axi_rvalid,       // read data valid
	input  wire logic                             s_axi_rready,       // read data ready
	output logic [31:0]                           s_axi_rdata,        // read data
	output logic [1:0]                            s_axi_rresp,        // read response
	output logic [NUM_CS-1:0]                     cs_n,               // chip selects
	output logic                                  ale,                // address latch enable
	output logic                                  rd_n,               // read strobe
	output logic                                  wr_n,               // write strobe
	output logic                                  byte_high_enable_n, // upper byte enable
	output logic [ebc_pkg::ADDR_LINES-1:0]        addr_lines,         // address lines
	input  wire logic [ebc_pkg::DATA_LINES-1:0]   shared_addr_data_i, // shared lines in
	output logic [ebc_pkg::DATA_LINES-1:0]        shared_addr_data_o, // shared lines out
	output logic                                  shared_addr_data_oe_n, // low drives shared lines
	input  wire logic [ebc_pkg::DATA_LINES-1:0]   data_lines_i,       // data lines in
	output logic [ebc_pkg::DATA_LINES-1:0]        data_lines_o,       // data lines out
	output logic                                  data_lines_oe_n,    // low drives data lines
	input  wire logic                             ready_in,           // ready handshake pin
	output logic                                  bus_ref_clock       // reference clock out
);
	import ebc_pkg::*;

	localparam int CSW = (NUM_CS > 1) ? $clog2(NUM_CS) : 1;

	typedef struct packed {
		logic                               awready;
		logic                               wready;
		logic                               bvalid;
		logic [1:0]                         bresp;
		logic                               arready;
		logic                               rvalid;
		logic [31:0]                        rdata;
		logic [1:0]                         rresp;
		logic                               aw_ok;
		logic [REG_AW-1:0]                  aw_off;
		logic                               w_ok;
		logic [31:0]                        wd;
		logic [3:0]                         ws;
		logic [CTRL_W-1:0]                  ctrl;
		logic [ADDR_LINES-1:0]              addr;
		logic [DATA_LINES-1:0]              wdat;
		logic [DATA_LINES-1:0]              rdat;
		logic [NUM_CS-1:0][CFG_W-1:0]       tcfg;
		logic [CSW-1:0]                     cs;
		logic [CSW-1:0]                     last_cs;
		logic                               wr;
		logic                               byte_high_enable;
		ph_type                             ph;
		logic [4:0]                         cnt;
		logic [2:0]                         rsync;
		logic                               rlvl;
		logic                               rx;
		logic [NUM_CS-1:0]                  cs_n;
		logic                               ale;
		logic                               rd_n;
		logic                               wr_n;
		logic                               bhe_n;
		logic [DATA_LINES-1:0]              sad_o;
		logic                               sad_oe_n;
		logic [DATA_LINES-1:0]              dat_o;
		logic                               dat_oe_n;
	} st_type;

	st_type           st_r;
	st_type           st_nxt;
	logic [CFG_W-1:0] cfg;
	logic             rdy_act;
	logic             win;
	logic [31:0]      wv;
	logic [32:0]      rv;
	logic             mux;

	function automatic logic [5:0] plen(ph_type p, logic [CFG_W-1:0] c, logic w);
		plen = 6'h00;
		unique case (p)
			PH_AB:   plen = 6'h01 + {5'h00, c[CFG_AB]} + (w ? {4'h0, c[CFG_WIN+:2]} : 6'h00); // see RQ3
			PH_C:    plen = {4'h0, c[CFG_C+:2]}; // see RQ4
			PH_D:    plen = {5'h00, c[CFG_D]}; // see RQ4
			PH_E:    plen = {1'h0, c[CFG_E+:5]} + 6'h01; // see RQ5
			PH_F:    plen = {4'h0, c[CFG_F+:2]}; // see RQ4
			PH_IDLE: plen = 6'h00;
		endcase
	endfunction

	// next phase with a nonzero length
	function automatic ph_type nxt(ph_type p, logic [CFG_W-1:0] c);
		nxt = PH_IDLE;
		unique case (p)
			PH_AB:   nxt = (c[CFG_C+:2] != 2'h0) ? PH_C : (c[CFG_D] ? PH_D : PH_E); // see RQ14
			PH_C:    nxt = c[CFG_D] ? PH_D : PH_E; // see RQ14
			PH_D:    nxt = PH_E;
			PH_E:    nxt = (c[CFG_F+:2] != 2'h0) ? PH_F : PH_IDLE; // see RQ14
			PH_F:    nxt = PH_IDLE;
			PH_IDLE: nxt = PH_IDLE;
		endcase
	endfunction

	function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] d, logic [3:0] s);
		mrg = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				mrg[8*b+:8] = d[8*b+:8];
			end
		end
	endfunction

	function automatic logic tcfg_hit(logic [REG_AW-1:0] o);
		tcfg_hit = (o[7:5] == TCFG_PAGE) && (o[1:0] == 2'h0) && (int'(o[4:2]) < NUM_CS);
	endfunction

	// {ok, value} of a register
	function automatic logic [32:0] regrd(st_type s, logic [REG_AW-1:0] o);
		regrd = {1'h1, 32'h00000000};
		if (o == OFF_CTRL) begin
			regrd[CTRL_W-1:0] = s.ctrl;
		end else if (o == OFF_ADDR) begin
			regrd[ADDR_LINES-1:0] = s.addr;
		end else if (o == OFF_CMD) begin
			regrd[CMD_WR] = s.wr;
			regrd[CMD_BHE] = s.byte_high_enable;
			regrd[CMD_CS+:CSW] = s.cs;
		end else if (o == OFF_WDATA) begin
			regrd[DATA_LINES-1:0] = s.wdat;
		end else if (o == OFF_STAT) begin
			regrd[0] = (s.ph != PH_IDLE);
		end else if (o == OFF_RDATA) begin
			regrd[DATA_LINES-1:0] = s.rdat;
		end else if (tcfg_hit(o)) begin
			regrd[CFG_W-1:0] = s.tcfg[CSW'(o[4:2])];
		end else begin
			regrd[32] = 1'h0;
		end
	endfunction

	always_comb begin
		st_nxt = st_r;
		cfg = st_r.tcfg[st_r.cs]; // see RQ2
		win = 1'h0;
		wv = 32'h00000000;
		rv = 33'h000000000;

		// ready pin: third stage agreeing with second sets the level
		st_nxt.rsync = {st_r.rsync[1:0], ready_in};
		if (st_r.rsync[2] == st_r.rsync[1]) begin
			st_nxt.rlvl = st_r.rsync[2];
		end
		st_nxt.rx = st_r.rlvl;
		rdy_act = (st_r.ctrl[CTRL_RASYNC] ? st_r.rx : st_r.rlvl) == st_r.ctrl[CTRL_RPOL]; // see RQ12

		// phase sequencer
		if (st_r.ph != PH_IDLE) begin // see RQ1
			if (st_r.cnt != 5'h00) begin
				st_nxt.cnt = st_r.cnt - 5'h01;
			end else if (st_r.ph == PH_E && cfg[CFG_RDY] && !rdy_act) begin
				st_nxt.cnt = 5'h00; // see RQ11
			end else begin
				if (st_r.ph == PH_E && !st_r.wr) begin
					// pins sampled on the edge that ends the strobe
					st_nxt.rdat = cfg[CFG_MUX] ? shared_addr_data_i : data_lines_i; // see RQ6 RQ7 RQ8
				end
				st_nxt.ph = nxt(st_r.ph, cfg);
				st_nxt.cnt = 5'(plen(st_nxt.ph, cfg, 1'h0) - 6'h01);
			end
		end

		// write channel
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_ok = 1'h1;
			st_nxt.aw_off = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_ok = 1'h1;
			st_nxt.wd = s_axi_wdata;
			st_nxt.ws = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'h0;
		end
		if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
			rv = regrd(st_r, st_r.aw_off);
			wv = mrg(rv[31:0], st_r.wd, st_r.ws);
			st_nxt.bresp = RESP_OKAY;
			if (st_r.aw_off == OFF_CTRL) begin
				st_nxt.ctrl = wv[CTRL_W-1:0];
			end else if (st_r.aw_off == OFF_ADDR) begin
				st_nxt.addr = wv[ADDR_LINES-1:0];
			end else if (st_r.aw_off == OFF_WDATA) begin
				st_nxt.wdat = wv[DATA_LINES-1:0];
			end else if (st_r.aw_off == OFF_CMD) begin
				if (st_r.ph != PH_IDLE || !st_r.ws[0] || int'(wv[CMD_CS+:CSW]) >= NUM_CS) begin
					st_nxt.bresp = RESP_SLVERR;
				end else begin
					st_nxt.wr = wv[CMD_WR];
					st_nxt.byte_high_enable = wv[CMD_BHE];
					st_nxt.cs = wv[CMD_CS+:CSW];
					win = (st_nxt.cs != st_r.last_cs);
					st_nxt.last_cs = st_nxt.cs;
					st_nxt.ph = PH_AB; // see RQ1
					st_nxt.cnt = 5'(plen(PH_AB, st_r.tcfg[st_nxt.cs], win) - 6'h01); // see RQ3
				end
			end else if (tcfg_hit(st_r.aw_off)) begin
				st_nxt.tcfg[CSW'(st_r.aw_off[4:2])] = wv[CFG_W-1:0]; // see RQ2
			end else if (!rv[32]) begin
				st_nxt.bresp = RESP_SLVERR;
			end
			st_nxt.bvalid = 1'h1;
			st_nxt.aw_ok = 1'h0;
			st_nxt.w_ok = 1'h0;
		end
		st_nxt.awready = !st_nxt.aw_ok;
		st_nxt.wready = !st_nxt.w_ok;

		// read channel
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'h0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			rv = regrd(st_r, s_axi_araddr);
			st_nxt.rvalid = 1'h1;
			st_nxt.rdata = rv[31:0];
			st_nxt.rresp = rv[32] ? RESP_OKAY : RESP_SLVERR;
		end
		st_nxt.arready = !st_nxt.rvalid;

		// pin levels for the coming phase
		mux = st_nxt.tcfg[st_nxt.cs][CFG_MUX];
		for (int i = 0; i < NUM_CS; i++) begin
			st_nxt.cs_n[i] = !(st_nxt.ph != PH_IDLE && st_nxt.cs == CSW'(i));
		end
		st_nxt.ale = (st_nxt.ph == PH_AB);
		st_nxt.rd_n = !(st_nxt.ph == PH_E && !st_nxt.wr);
		st_nxt.wr_n = !(st_nxt.ph == PH_E && st_nxt.wr);
		st_nxt.bhe_n = !(st_nxt.ph != PH_IDLE && st_nxt.byte_high_enable);
		st_nxt.sad_o = st_nxt.addr[DATA_LINES-1:0];
		st_nxt.sad_oe_n = 1'h1;
		st_nxt.dat_o = st_nxt.wdat;
		st_nxt.dat_oe_n = 1'h1;
		if (mux) begin
			if (st_nxt.ph == PH_AB || st_nxt.ph == PH_C) begin
				st_nxt.sad_oe_n = 1'h0; // see RQ9
			end else if (st_nxt.ph != PH_IDLE && st_nxt.wr) begin
				st_nxt.sad_o = st_nxt.wdat; // see RQ9
				st_nxt.sad_oe_n = 1'h0;
			end
		end else if (st_nxt.wr && (st_nxt.ph == PH_D || st_nxt.ph == PH_E || st_nxt.ph == PH_F)) begin
			st_nxt.dat_oe_n = 1'h0; // see RQ9
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.awready <= 1'h1;
			st_r.wready <= 1'h1;
			st_r.arready <= 1'h1;
			st_r.ctrl <= CTRL_RST;
			st_r.tcfg <= {NUM_CS{CFG_RST}};
			st_r.ph <= PH_IDLE;
			st_r.cs_n <= '1;
			st_r.rd_n <= 1'h1;
			st_r.wr_n <= 1'h1;
			st_r.bhe_n <= 1'h1;
			st_r.sad_oe_n <= 1'h1;
			st_r.dat_oe_n <= 1'h1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign cs_n = st_r.cs_n;
	assign ale = st_r.ale;
	assign rd_n = st_r.rd_n;
	assign wr_n = st_r.wr_n;
	assign byte_high_enable_n = st_r.bhe_n;
	assign addr_lines = st_r.addr;
	assign shared_addr_data_o = st_r.sad_o;
	assign shared_addr_data_oe_n = st_r.sad_oe_n;
	assign data_lines_o = st_r.dat_o;
	assign data_lines_oe_n = st_r.dat_oe_n;
	// system clock gated onto the pin, so one period per system clock
	assign bus_ref_clock = core_clk & st_r.ctrl[CTRL_REFEN]; // see RQ10
endmodule // ext_bus_ctrl

// ===== tb/ebc_properties.sv
/*
 checker: phase order and pin relations of the external bus cycle.
 assumes bind onto ext_bus_ctrl, one clock domain.
*/
`timescale 1ns/10ps
module ebc_props #(
	parameter int NUM_CS = 2
) (
	input wire logic                         core_clk,              // system clock
	input wire logic                         nrst,                  // sync reset
	input wire logic [NUM_CS-1:0]            cs_n,                  // selects
	input wire logic                         ale,                   // latch pulse
	input wire logic                         rd_n,                  // read strobe
	input wire logic                         wr_n,                  // write strobe
	input wire logic [ebc_pkg::ADDR_LINES-1:0] addr_lines,          // address
	input wire logic [ebc_pkg::DATA_LINES-1:0] shared_addr_data_o,  // shared out
	input wire logic                         shared_addr_data_oe_n, // shared enable
	input wire logic                         data_lines_oe_n        // data enable
);
	import ebc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire idle = &cs_n;
	wire strb = !(rd_n && wr_n);
	a_start_latch: assert property ($fell(idle) |-> ale)
		else $error("cycle began without latch pulse");
	a_latch_in_cycle: assert property (ale |-> !idle)
		else $error("latch pulse outside a cycle");
	a_strobe_after_setup: assert property (strb |-> !ale && !idle && (rd_n || wr_n))
		else $error("strobe overlaps setup or idle");
	a_setup_len: assert property ($rose(ale) |-> ##[1:5] !ale)
		else $error("setup longer than five periods");
	a_delay_len: assert property ($fell(ale) && !idle |-> ##[0:4] strb)
		else $error("access not reached after delay");
	a_hold_len: assert property ($fell(strb) |-> ##[0:3] idle)
		else $error("hold longer than three periods");
	a_read_release: assert property (!rd_n |-> shared_addr_data_oe_n && data_lines_oe_n)
		else $error("lines driven during read");
	a_write_drive: assert property (!wr_n |-> shared_addr_data_oe_n != data_lines_oe_n)
		else $error("write data not on one line set");
	a_mux_address: assert property (ale && !shared_addr_data_oe_n |-> shared_addr_data_o == addr_lines[15:0])
		else $error("shared lines not showing address");
	a_addr_steady: assert property (!idle && !$fell(idle) |-> $stable(addr_lines))
		else $error("address moved inside a cycle");
endmodule // ebc_props

bind ext_bus_ctrl ebc_props #(.NUM_CS(NUM_CS)) u_props (
	.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .addr_lines(addr_lines),
	.shared_addr_data_o(shared_addr_data_o), .shared_addr_data_oe_n(shared_addr_data_oe_n),
	.data_lines_oe_n(data_lines_oe_n)
);

// ===== tb/ext_mem_model.sv
/*
 partner: memory or peripheral on the parallel bus.
 assumes strobes are timed to core_clk.
*/
`timescale 1ns/10ps
module ext_mem_model (
	input wire logic        core_clk,  // system clock
	input wire logic        rd_n,      // read strobe
	input wire logic        wr_n,      // write strobe
	input wire logic [15:0] rd_value,  // data to return
	input wire logic        rdy_level, // active ready level
	input wire logic [3:0]  rdy_waits, // strobe cycles before ready
	output logic     [15:0] rd_data,   // data toward bus
	output logic            ready      // ready pin
);
	logic [3:0] cnt = 4'h0;
	wire        strb = !(rd_n && wr_n);
	// released data turns to its inverse
	assign rd_data = rd_n ? ~rd_value : rd_value;
	always @(posedge core_clk) cnt <= strb ? cnt + 4'(cnt != 4'hF) : 4'h0;
	// ready dropped as the strobe rises
	assign ready = (strb && cnt >= rdy_waits) ? rdy_level : !rdy_level;
endmodule // ext_mem_model

// ===== tb/tb_external_bus_cycle_phases.sv
/*
 testbench: phase lengths, data paths, ready and refusals of ext_bus_ctrl.
 assumes ext_mem_model on the far side.
*/
`timescale 1ns/10ps
module tb_external_bus_cycle_phases;
	import ebc_pkg::*;
	logic core_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, ale, rd_n, wr_n, byte_high_enable_n, ready_in, bus_ref_clock;
	logic shared_addr_data_oe_n, data_lines_oe_n, rdy_level = 1, busy_p = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hF, rdy_waits = 4'h3;
	logic [1:0] s_axi_bresp, s_axi_rresp, cs_n;
	logic [23:0] addr_lines;
	logic [15:0] shared_addr_data_o, data_lines_o, mem_d, cap_w, rd_value = 0;
	wire [15:0] shared_addr_data_i = shared_addr_data_oe_n ? mem_d : shared_addr_data_o;
	wire [15:0] data_lines_i = data_lines_oe_n ? mem_d : data_lines_o;
	int fails = 0, tests_run = 0, n_ab, n_cd, n_e, n_f, n_bhe, n_done = 0;
	ext_bus_ctrl dut (
		.core_clk(core_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .cs_n(cs_n),
		.ale(ale), .rd_n(rd_n), .wr_n(wr_n), .byte_high_enable_n(byte_high_enable_n), .addr_lines(addr_lines),
		.shared_addr_data_i(shared_addr_data_i), .shared_addr_data_o(shared_addr_data_o),
		.shared_addr_data_oe_n(shared_addr_data_oe_n), .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
		.data_lines_oe_n(data_lines_oe_n), .ready_in(ready_in), .bus_ref_clock(bus_ref_clock)
	);
	ext_mem_model mem (.core_clk, .rd_n, .wr_n, .rd_value, .rdy_level, .rdy_waits, .rd_data(mem_d), .ready(ready_in));
	always #50 core_clk = ~core_clk;
	// phase counters from pin levels
	always @(posedge core_clk) begin
		if (!(&cs_n)) begin
			if (ale) n_ab++;
			else if (!(rd_n && wr_n)) n_e++;
			else if (n_e == 0) n_cd++;
			else n_f++;
			if (!wr_n) cap_w = data_lines_oe_n ? shared_addr_data_o : data_lines_o;
		end
		if (!byte_high_enable_n) n_bhe++;
		if (busy_p && &cs_n) n_done++;
		busy_p = !(&cs_n);
	end
	task finish_test;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task tmo;
		fails++;
		finish_test;
	endtask
	task wr32(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1; s_axi_wdata <= d; s_axi_bready <= 1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid && n < 50);
		if (n >= 50) tmo;
		chk(s_axi_bresp, er);
		s_axi_bready <= 0;
		@(posedge core_clk);
	endtask
	task rd32(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid && n < 50);
		if (n >= 50) tmo;
		d = s_axi_rdata;
		chk(s_axi_rresp, er);
		s_axi_rready <= 0;
		@(posedge core_clk);
	endtask
	task go(input int sel, input int wr, input bit busy_try);
		int k, n0;
		n_ab = 0; n_cd = 0; n_e = 0; n_f = 0; n0 = n_done; k = 0;
		n_bhe = 0;
		wr32(OFF_CMD, {23'h0, 1'(sel), 6'h0, 1'(wr), 1'(wr)}, RESP_OKAY);
		if (busy_try) wr32(OFF_CMD, 32'h1, RESP_SLVERR);
		while (n_done == n0 && k < 300) begin
			@(posedge core_clk);
			k++;
		end
		if (k >= 300) tmo;
	endtask
	task run(input int sel, wr, ab, c, d, e, f, wc, mux, exp_ab);
		logic [15:0] wd;
		wd = 16'hC3A5 ^ 16'(e * 257);
		wr32(8'h20 + 8'(4 * sel), {17'h0, 1'(mux), 1'b0, 2'(wc), 2'(f), 5'(e), 1'(d), 2'(c), 1'(ab)}, RESP_OKAY);
		wr32(OFF_WDATA, {16'h0, wd}, RESP_OKAY);
		rd_value <= ~wd;
		go(sel, wr, e == 31);
		chk(n_ab, exp_ab);
		chk(n_cd, c + d);
		chk(n_e, e + 1);
		chk(n_f, f);
		chk(n_bhe, wr ? exp_ab + c + d + e + 1 + f : 0);
		if (wr) chk(cap_w, wd);
		else begin
			rd32(OFF_RDATA, v, RESP_OKAY);
			chk(v, rd_value);
		end
	endtask
	task t_misc;
		int n0;
		n0 = n_done;
		rd32(OFF_CTRL, v, RESP_OKAY);
		chk(v, 32'(CTRL_RST));
		rd32(8'h20, v, RESP_OKAY);
		chk(v, 32'(CFG_RST));
		rd32(8'h18, v, RESP_SLVERR);
		chk(v, 32'h0);
		wr32(8'h18, 32'h1, RESP_SLVERR);
		wr32(OFF_ADDR, 32'h00A1B2C3, RESP_OKAY);
		chk(addr_lines, 32'h00A1B2C3);
		#20 chk(bus_ref_clock, 0);
		@(posedge core_clk);
		s_axi_wstrb <= 4'h2;
		wr32(OFF_ADDR, 32'h00FFEEDD, RESP_OKAY);
		wr32(OFF_CMD, 32'h1, RESP_SLVERR);
		s_axi_wstrb <= 4'hF;
		rd32(OFF_ADDR, v, RESP_OKAY);
		chk(v, 32'h00A1EEC3);
		chk(n_done, n0);
	endtask
	task t_cycles;
		run(0, 1, 0, 0, 0, 0, 0, 0, 0, 1);
		run(0, 0, 1, 3, 1, 31, 3, 0, 1, 2);
		run(1, 1, 0, 2, 0, 4, 1, 3, 0, 4);
		run(1, 0, 1, 1, 1, 0, 2, 2, 0, 2);
		run(0, 1, 1, 0, 1, 2, 0, 2, 1, 4);
	endtask
	task t_ready;
		int es;
		wr32(8'h20, 32'h00002000, RESP_OKAY);
		for (int p = 0; p < 2; p++) begin
			for (int a = 0; a < 2; a++) begin
				rdy_level <= 1'(p);
				wr32(OFF_CTRL, 32'(4 + 2 * a + p), RESP_OKAY);
				go(0, 0, 0);
				chk(n_e >= 4, 1);
				if (a == 1) chk(n_e > es, 1);
				es = n_e;
			end
		end
		#20 chk(bus_ref_clock, 1);
		#50 chk(bus_ref_clock, 0);
		@(posedge core_clk);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1;
		@(posedge core_clk);
		t_misc;
		t_cycles;
		t_ready;
		finish_test;
	end
endmodule // tb_external_bus_cycle_phases
